// ### logic/usc_map.svh
// Behaviour
// RULE1: multiprocessor mode drops frames lacking address bit
// RULE2: receive interrupt needs enable, global flag, flag
// RULE3: transmit-done interrupt needs enable, global flag, flag
// RULE4: empty-buffer interrupt needs enable, global flag, flag
// RULE5: receiver enable owns pin; disable flushes errors
// RULE6: transmitter disable waits for drain, then releases
// RULE7: size code selects 5 to 9 bits
// RULE8: received ninth bit read before low byte
// RULE9: ninth transmit bit captured with byte write
// RULE10: mode bit selects asynchronous or synchronous
// RULE11: parity off, even or odd; receiver checks
// RULE12: transmitter sends one or two stop bits
// RULE13: clock polarity picks change and sample edges
// RULE14: twelve-bit divisor split low and high bytes
// RULE15: low divisor write reloads the prescaler immediately; the code reloads it one clock after the write, via registered baudReload
// RULE16: short characters ignore upper bits, receive zeros
// RULE17: double speed halves samples per bit
// RULE18: transmit-done clears on service or write one
// RULE19: unused divisor and format bits read zero
`ifndef USC_MAP_SVH
`define USC_MAP_SVH

// register offsets
`define USC_OFS_FRAME 8'h20
`define USC_OFS_BAUD_LO 8'h99
`define USC_OFS_CTRL 8'h9A
`define USC_OFS_BAUD_HI 8'h98
`define USC_OFS_STATUS 8'h9B
`define USC_OFS_DATA 8'h0C

// field positions
`define USC_STAT_TXDONE 6
`define USC_STAT_DOUBLE 1
`define USC_STAT_MULTI 0

// reset values
`define USC_RST_FRAME 7'h06
`define USC_RST_CTRL 8'h00

// oversampling counts, last index and mid index
`define USC_OS_LAST_NORM 4'hF
`define USC_OS_LAST_DBL 4'h7
`define USC_OS_MID_NORM 4'h7
`define USC_OS_MID_DBL 4'h3

`endif

// ### logic/usc_pkg.sv
`default_nettype none

package usc_pkg;

    // one received character with its status
    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic frameErr;
        logic parityErr;
    } uscRxEntry_t;

    // decoded frame format
    typedef struct packed {
        logic syncMode;
        logic parityEn;
        logic parityOdd;
        logic twoStop;
        logic [3:0] dataBits;
        logic polarity;
    } uscFrameCfg_t;

    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} uscTxState_t;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} uscRxState_t;

endpackage

`default_nettype wire

// ### logic/usc_fifo2.sv
`timescale 1ns/10ps
`default_nettype none

module usc_fifo2 #(
    parameter int W = 11,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic flush,
    input wire logic inValid,
    input wire logic [W-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [W-1:0] outData,
    input wire logic outReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] store [DEPTH]; // entries, no reset needed
    logic [AW-1:0] wrPtr; // next slot to fill
    logic [AW-1:0] rdPtr; // oldest entry
    logic [AW:0] count; // entries held
    logic push;
    logic pop;

    assign inReady = count != (AW+1)'(DEPTH);
    assign outValid = count != '0;
    assign outData = store[rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // wrapping pointer step
    function automatic logic [AW-1:0] stepPtr(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            store[wrPtr] <= inData;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk) begin
        if (srst || flush) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= stepPtr(wrPtr);
            end
            if (pop) begin
                rdPtr <= stepPtr(rdPtr);
            end
            if (push && !pop) begin
                count <= count + (AW+1)'(1);
            end else if (pop && !push) begin
                count <= count - (AW+1)'(1);
            end
        end
    end

endmodule

`default_nettype wire

// ### logic/usc_baud_gen.sv
`timescale 1ns/10ps
`default_nettype none

module usc_baud_gen #(
    parameter int DW = 12
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic reload,
    input wire logic [DW-1:0] divisor,
    output logic tick
);
    logic [DW-1:0] count; // down counter

    // one tick every divisor+1 clocks
    always_ff @(posedge clk) begin
        if (srst || reload) begin
            count <= divisor; // RULE15
            tick <= 1'b0;
        end else if (count == '0) begin
            count <= divisor;
            tick <= 1'b1;
        end else begin
            count <= count - DW'(1);
            tick <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### logic/usc_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "usc_map.svh"

module usc_control
    import usc_pkg::*;
#(
    parameter int DIV_W = 12,
    parameter int RX_DEPTH = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic globalIrqEn,
    input wire logic txDoneIrqAck,
    output logic irqRxDone,
    output logic irqTxDone,
    output logic irqTxEmpty,
    input wire logic serialInPin,
    output logic serialOutPin,
    output logic serialOutOe,
    output logic syncClockOut,
    output logic syncClockOe,
    output logic rxPinOwned
);
    localparam int EW = $bits(uscRxEntry_t);

    // software-visible configuration
    logic [6:0] frameFmt; // format bits 6:0
    logic rxDoneIrqEn;
    logic txDoneIrqEn;
    logic txEmptyIrqEn;
    logic receiverEn;
    logic transmitterEn;
    logic charSizeMsb;
    logic txNinthBit;
    logic doubleSpeedBit;
    logic multiprocFilterEn;
    logic [DIV_W-1:0] baudDiv;
    logic baudReload; // pulse after low byte write
    uscFrameCfg_t cfg;

    // status flags
    logic txEmptyFlag;
    logic txDoneFlag;
    logic overrunFlag;
    logic rxDoneFlag;

    // transmit path
    uscTxState_t txState;
    logic [7:0] txBuf;
    logic txBufNinth;
    logic [12:0] txShift;
    logic [3:0] txLeft; // bits still to send
    logic [3:0] txOs; // oversample phase
    logic txFrameEnd; // pulse when last bit done
    logic txLoad;
    logic txStep;
    logic [3:0] frameLen;

    // receive path
    uscRxState_t rxState;
    logic [3:0] rxOs;
    logic [3:0] rxCnt; // bits received after start
    logic [8:0] rxData;
    logic rxParBit;
    logic rxPush;
    logic rxOverrun;
    uscRxEntry_t rxEntry;
    uscRxEntry_t rxHead;
    logic rxStep;
    logic rxAddrBit;
    logic fifoInReady;

    // timing
    logic tick;
    logic syncPhase;
    logic changeEdge;
    logic sampleEdge;
    logic [3:0] osLast;
    logic [3:0] osMid;

    // access strobes
    logic wrFrame;
    logic wrCtrl;
    logic wrStatus;
    logic wrBaudLo;
    logic wrBaudHi;
    logic wrData;
    logic rdData;

    assign wrFrame = regWrite && regAddr == `USC_OFS_FRAME;
    assign wrCtrl = regWrite && regAddr == `USC_OFS_CTRL;
    assign wrStatus = regWrite && regAddr == `USC_OFS_STATUS;
    assign wrBaudLo = regWrite && regAddr == `USC_OFS_BAUD_LO;
    assign wrBaudHi = regWrite && regAddr == `USC_OFS_BAUD_HI;
    assign wrData = regWrite && regAddr == `USC_OFS_DATA;
    assign rdData = regRead && regAddr == `USC_OFS_DATA;

    // size code to bit count, reserved as eight
    function automatic logic [3:0] charBits(input logic msb, input logic [1:0] lsbs);
        if (msb && lsbs == 2'h3) begin
            return 4'h9;
        end
        if (msb) begin
            return 4'h8;
        end
        return 4'h5 + {2'h0, lsbs};
    endfunction

    // parity over the first n data bits
    function automatic logic parityOf(input logic [8:0] d, input logic [3:0] n,
                                      input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(n)) begin
                p = p ^ d[i];
            end
        end
        return p;
    endfunction

    // lsb-first frame
    function automatic logic [12:0] buildFrame(input logic [8:0] d, input logic [3:0] n,
                                               input logic pe, input logic odd);
        logic [12:0] f;
        f = '1;
        f[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(n)) begin
                f[i + 1] = d[i]; // RULE16
            end
        end
        if (pe) begin
            f[int'(n) + 1] = parityOf(d, n, odd); // RULE11
        end
        return f;
    endfunction

    // decode the format fields
    always_comb begin
        cfg.syncMode = frameFmt[6]; // RULE10
        cfg.parityEn = frameFmt[5]; // RULE11
        cfg.parityOdd = frameFmt[4];
        cfg.twoStop = frameFmt[3];
        cfg.dataBits = charBits(charSizeMsb, frameFmt[2:1]); // RULE7
        cfg.polarity = frameFmt[0];
    end

    // samples per bit
    assign osLast = doubleSpeedBit ? `USC_OS_LAST_DBL : `USC_OS_LAST_NORM; // RULE17
    assign osMid = doubleSpeedBit ? `USC_OS_MID_DBL : `USC_OS_MID_NORM;

    // total bits on the line; stop count only shapes transmit
    assign frameLen = 4'h1 + cfg.dataBits + {3'h0, cfg.parityEn}
                      + (cfg.twoStop ? 4'h2 : 4'h1); // RULE12

    // configuration registers
    always_ff @(posedge clk) begin
        if (srst) begin
            frameFmt <= `USC_RST_FRAME;
            {rxDoneIrqEn, txDoneIrqEn, txEmptyIrqEn, receiverEn} <= 4'(`USC_RST_CTRL >> 4);
            {transmitterEn, charSizeMsb, txNinthBit} <= 3'h0;
            doubleSpeedBit <= 1'b0;
            multiprocFilterEn <= 1'b0;
        end else begin
            if (wrFrame) begin
                frameFmt <= regWdata[6:0]; // RULE19
            end
            if (wrCtrl) begin
                {rxDoneIrqEn, txDoneIrqEn, txEmptyIrqEn} <= regWdata[7:5];
                receiverEn <= regWdata[4];
                transmitterEn <= regWdata[3];
                charSizeMsb <= regWdata[2];
                txNinthBit <= regWdata[0];
            end
            if (wrStatus) begin
                doubleSpeedBit <= regWdata[`USC_STAT_DOUBLE];
                multiprocFilterEn <= regWdata[`USC_STAT_MULTI];
            end
        end
    end

    // baud divisor bytes and reload strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            baudDiv <= '0;
            baudReload <= 1'b0;
        end else begin
            baudReload <= wrBaudLo; // RULE15
            if (wrBaudLo) begin
                baudDiv[7:0] <= regWdata; // RULE14
            end
            if (wrBaudHi) begin
                baudDiv[DIV_W-1:8] <= regWdata[DIV_W-9:0]; // RULE19
            end
        end
    end

    // prescaler
    usc_baud_gen #(
        .DW(DIV_W)
    ) u_baud (
        .clk(clk),
        .srst(srst),
        .reload(baudReload),
        .divisor(baudDiv),
        .tick(tick)
    );

    // synchronous clock phase and edges
    always_ff @(posedge clk) begin
        if (srst || !cfg.syncMode) begin
            syncPhase <= 1'b0;
        end else if (tick) begin
            syncPhase <= !syncPhase;
        end
    end

    assign changeEdge = cfg.syncMode && tick && !syncPhase;
    assign sampleEdge = cfg.syncMode && tick && syncPhase;

    // sync clock pin; polarity swaps change and sample edges
    always_ff @(posedge clk) begin
        if (srst) begin
            syncClockOut <= 1'b0;
            syncClockOe <= 1'b0;
        end else begin
            syncClockOut <= syncPhase ^ cfg.polarity; // RULE13
            syncClockOe <= cfg.syncMode && (serialOutOe || receiverEn);
        end
    end

    // transmit buffer and empty flag
    always_ff @(posedge clk) begin
        if (srst) begin
            txBuf <= 8'h00;
            txBufNinth <= 1'b0;
            txEmptyFlag <= 1'b1;
        end else if (wrData && txEmptyFlag) begin
            txBuf <= regWdata;
            txBufNinth <= txNinthBit; // RULE9
            txEmptyFlag <= 1'b0;
        end else if (txLoad) begin
            txEmptyFlag <= 1'b1;
        end
    end

    assign txLoad = txState == TX_IDLE && !txEmptyFlag && serialOutOe;
    assign txStep = cfg.syncMode ? changeEdge : (tick && txOs == osLast);

    // transmit shifter
    always_ff @(posedge clk) begin
        if (srst) begin
            txState <= TX_IDLE;
            txShift <= '1;
            txLeft <= 4'h0;
            txOs <= 4'h0;
            txFrameEnd <= 1'b0;
        end else begin
            txFrameEnd <= 1'b0;
            case (txState)
                TX_IDLE: begin
                    txOs <= 4'h0;
                    if (txLoad) begin
                        txShift <= buildFrame({txBufNinth, txBuf}, cfg.dataBits,
                                              cfg.parityEn, cfg.parityOdd);
                        txLeft <= frameLen;
                        txState <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    // count samples within a bit
                    if (tick && !cfg.syncMode) begin
                        txOs <= (txOs == osLast) ? 4'h0 : txOs + 4'h1;
                    end
                    if (txStep) begin
                        txShift <= {1'b1, txShift[12:1]};
                        txLeft <= txLeft - 4'h1;
                        if (txLeft == 4'h1) begin
                            txState <= TX_IDLE;
                            txFrameEnd <= 1'b1;
                        end
                    end
                end
                default: txState <= TX_IDLE;
            endcase
        end
    end

    // transmit pin ownership and level
    always_ff @(posedge clk) begin
        if (srst) begin
            serialOutOe <= 1'b0;
            serialOutPin <= 1'b1;
        end else begin
            // hold pin until drained
            serialOutOe <= transmitterEn
                           || (serialOutOe && (txState != TX_IDLE || !txEmptyFlag)); // RULE6
            serialOutPin <= (txState == TX_SHIFT) ? txShift[0] : 1'b1;
        end
    end

    // transmit complete, set beats clear
    always_ff @(posedge clk) begin
        if (srst) begin
            txDoneFlag <= 1'b0;
        end else if (txFrameEnd && txEmptyFlag) begin
            txDoneFlag <= 1'b1;
        end else if (txDoneIrqAck || (wrStatus && regWdata[`USC_STAT_TXDONE])) begin
            txDoneFlag <= 1'b0; // RULE18
        end
    end

    assign rxStep = cfg.syncMode ? sampleEdge : (tick && rxOs == osLast);
    assign rxAddrBit = rxData[cfg.dataBits - 4'h1];

    // receive sequencer; disabling resets it
    always_ff @(posedge clk) begin
        if (srst || !receiverEn) begin
            rxState <= RX_IDLE;
            rxOs <= 4'h0;
            rxCnt <= 4'h0;
            rxData <= 9'h000;
            rxParBit <= 1'b0;
            rxPush <= 1'b0;
            rxOverrun <= 1'b0;
            rxEntry <= '0;
        end else begin
            rxPush <= 1'b0;
            rxOverrun <= 1'b0;
            case (rxState)
                RX_IDLE: begin
                    rxOs <= 4'h0;
                    rxCnt <= 4'h0;
                    rxData <= 9'h000; // RULE16
                    // low line starts a frame
                    if (!serialInPin && (cfg.syncMode ? sampleEdge : tick)) begin
                        rxState <= cfg.syncMode ? RX_BITS : RX_START;
                    end
                end
                RX_START: begin
                    // recheck start bit at its middle
                    if (tick) begin
                        rxOs <= rxOs + 4'h1;
                        if (rxOs == osMid) begin
                            rxOs <= 4'h0;
                            rxState <= serialInPin ? RX_IDLE : RX_BITS;
                        end
                    end
                end
                RX_BITS: begin
                    if (tick && !cfg.syncMode) begin
                        rxOs <= (rxOs == osLast) ? 4'h0 : rxOs + 4'h1;
                    end
                    if (rxStep) begin
                        rxCnt <= rxCnt + 4'h1;
                        if (rxCnt < cfg.dataBits) begin
                            rxData[rxCnt] <= serialInPin;
                        end else if (cfg.parityEn && rxCnt == cfg.dataBits) begin
                            rxParBit <= serialInPin;
                        end else begin
                            // first stop bit ends the frame
                            rxState <= RX_IDLE;
                            rxEntry.data <= rxData[7:0];
                            rxEntry.ninth <= rxData[8];
                            rxEntry.frameErr <= !serialInPin;
                            rxEntry.parityErr <= cfg.parityEn && (rxParBit
                                != parityOf(rxData, cfg.dataBits, cfg.parityOdd)); // RULE11
                            if (!multiprocFilterEn || rxAddrBit) begin // RULE1
                                rxPush <= fifoInReady;
                                rxOverrun <= !fifoInReady;
                            end
                        end
                    end
                end
                default: rxState <= RX_IDLE;
            endcase
        end
    end

    // two-level receive buffer, flushed on disable
    usc_fifo2 #(
        .W(EW),
        .DEPTH(RX_DEPTH)
    ) u_rxbuf (
        .clk(clk),
        .srst(srst),
        .flush(!receiverEn), // RULE5
        .inValid(rxPush),
        .inData(rxEntry),
        .inReady(fifoInReady),
        .outValid(rxDoneFlag),
        .outData(rxHead),
        .outReady(rdData) // RULE8
    );

    // overrun, valid until the data is read
    always_ff @(posedge clk) begin
        if (srst) begin
            overrunFlag <= 1'b0;
        end else if (rxOverrun) begin
            overrunFlag <= 1'b1;
        end else if (rdData || !receiverEn) begin
            overrunFlag <= 1'b0; // RULE5
        end
    end

    // receive pin takeover
    always_ff @(posedge clk) begin
        if (srst) begin
            rxPinOwned <= 1'b0;
        end else begin
            rxPinOwned <= receiverEn; // RULE5
        end
    end

    // interrupt requests
    always_ff @(posedge clk) begin
        if (srst) begin
            irqRxDone <= 1'b0;
            irqTxDone <= 1'b0;
            irqTxEmpty <= 1'b0;
        end else begin
            irqRxDone <= rxDoneIrqEn && globalIrqEn && rxDoneFlag; // RULE2
            irqTxDone <= txDoneIrqEn && globalIrqEn && txDoneFlag; // RULE3
            irqTxEmpty <= txEmptyIrqEn && globalIrqEn && txEmptyFlag; // RULE4
        end
    end

    // read data, held
    always_ff @(posedge clk) begin
        if (srst) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                `USC_OFS_STATUS: regRdata <= {rxDoneFlag, txDoneFlag, txEmptyFlag,
                                              rxDoneFlag && rxHead.frameErr, overrunFlag,
                                              rxDoneFlag && rxHead.parityErr,
                                              doubleSpeedBit, multiprocFilterEn};
                `USC_OFS_CTRL: regRdata <= {rxDoneIrqEn, txDoneIrqEn, txEmptyIrqEn,
                                            receiverEn, transmitterEn, charSizeMsb,
                                            rxDoneFlag && rxHead.ninth, txNinthBit}; // RULE8
                `USC_OFS_FRAME: regRdata <= {1'b0, frameFmt}; // RULE19
                `USC_OFS_BAUD_LO: regRdata <= baudDiv[7:0];
                `USC_OFS_BAUD_HI: regRdata <= 8'(baudDiv[DIV_W-1:8]); // RULE19
                `USC_OFS_DATA: regRdata <= rxDoneFlag ? rxHead.data : 8'h00;
                default: regRdata <= 8'h00;
            endcase
        end
    end

endmodule

`default_nettype wire

// ### tb/usc_control_sva.sv
`timescale 1ns/10ps
`default_nettype none

module usc_control_sva (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic globalIrqEn,
    input wire logic txDoneIrqAck,
    input wire logic irqRxDone,
    input wire logic irqTxDone,
    input wire logic irqTxEmpty,
    input wire logic serialOutPin,
    input wire logic serialOutOe,
    input wire logic syncClockOe,
    input wire logic rxPinOwned
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // irqs need global flag
    property p_rx_irq; irqRxDone |-> $past(globalIrqEn); endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("rx irq");
    property p_tx_irq; irqTxDone |-> $past(globalIrqEn); endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("tx irq");
    property p_empty_irq; irqTxEmpty |-> $past(globalIrqEn); endproperty
    a_empty_irq: assert property (p_empty_irq) else $error("empty irq");
    // unused bits read zero
    property p_fmt_top; regRead && regAddr == 8'h20 |=> !regRdata[7]; endproperty
    a_fmt_top: assert property (p_fmt_top) else $error("format bit 7 set");
    property p_hi_top; regRead && regAddr == 8'h98 |=> regRdata[7:4] == 4'h0; endproperty
    a_hi_top: assert property (p_hi_top) else $error("baud high top bits set");
    // pin ownership
    property p_rx_own;
        regWrite && regAddr == 8'h9A |-> ##2 rxPinOwned == $past(regWdata[4], 2);
    endproperty
    a_rx_own: assert property (p_rx_own) else $error("rx pin ownership wrong");
    // idle release
    property p_oe_fall; $fell(serialOutOe) |-> serialOutPin; endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("tx released mid frame");
    property p_pin_fell; $fell(serialOutPin) |-> serialOutOe; endproperty
    a_pin_fell: assert property (p_pin_fell) else $error("tx line moved unowned");
    // service clears irq
    property p_ack; txDoneIrqAck |-> ##2 !irqTxDone; endproperty
    a_ack: assert property (p_ack) else $error("tx done irq stayed");
    c_rx: cover property (irqRxDone);
    c_release: cover property ($fell(serialOutOe));
    c_sync: cover property (syncClockOe);
endmodule

`default_nettype wire

// ### tb/usc_serial_peer.sv
`timescale 1ns/10ps
`default_nettype none

module usc_serial_peer (
    input wire logic clk,
    input wire logic lineIn,
    input wire logic [3:0] nBits,
    output logic lineOut,
    output logic [8:0] gotWord,
    output logic gotStb
);
    logic [8:0] w; // word being gathered
    initial begin
        lineOut = 1'b1;
        gotStb = 1'b0;
    end
    // send lsb first
    task automatic send(input logic [11:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            lineOut = bits[i];
            repeat (16) @(negedge clk);
        end
        lineOut = 1'b1;
    endtask
    // sample mid bit
    always begin
        @(negedge lineIn);
        w = 9'h000;
        repeat (8) @(negedge clk);
        for (int i = 0; i < nBits; i++) begin
            repeat (16) @(negedge clk);
            w[i] = lineIn;
        end
        repeat (16) @(negedge clk);
        gotWord = w;
        gotStb = 1'b1;
        @(negedge clk);
        gotStb = 1'b0;
    end
endmodule

`default_nettype wire

// ### tb/tb_usc_control.sv
`timescale 1ns/10ps
`default_nettype none

module tb_usc_control;
    logic clk, srst, regWrite, regRead, globalIrqEn, txDoneIrqAck, gotStb, n9;
    logic [7:0] regAddr, regWdata, regRdata, d, e, m;
    logic irqRxDone, irqTxDone, irqTxEmpty, serialInPin, serialOutPin;
    logic serialOutOe, syncClockOut, syncClockOe, rxPinOwned;
    logic [8:0] gotWord;
    logic [3:0] peerBits;
    logic [8:0] expQ[$], txQ[$];
    int badCount, totalChecks, seed, nb;
    usc_control dut (.*);
    usc_serial_peer peer (.clk(clk), .lineIn(serialOutPin), .nBits(peerBits),
        .lineOut(serialInPin), .gotWord(gotWord), .gotStb(gotStb));
    task check(input logic [8:0] s, input logic [8:0] x);
        totalChecks++;
        if (s !== x) begin
            badCount++;
            $display("[ERR] %0t saw %h want %h", $time, s, x);
        end
    endtask
    task closeOut;
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        regAddr = a;
        regWdata = v;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] x);
        @(negedge clk);
        regAddr = a;
        regRead = 1'b1;
        expQ.push_back({1'b0, x});
        @(negedge clk);
        regRead = 1'b0;
    endtask
    task waitq;
        for (int k = 0; k < 2000 && txQ.size() > 0; k++) @(negedge clk);
        if (txQ.size() > 0) begin
            check(9'h1FF, 9'h000);
            closeOut;
        end
        cyc(20);
    endtask
    always @(posedge clk) if (regRead === 1'b1) begin
        @(negedge clk);
        check({1'b0, regRdata}, expQ.pop_front());
    end
    always @(posedge gotStb) check(gotWord, txQ.pop_front());
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {regWrite, regRead, globalIrqEn, txDoneIrqAck} = 4'h0;
        {regAddr, regWdata} = 16'h0000;
        {badCount, totalChecks, seed, peerBits} = {32'h0, 32'h0, 32'hC178, 4'h8};
        srst = 1'b1;
        cyc(4);
        srst = 1'b0;
        rd(8'h20, 8'h06);
        rd(8'h9A, 8'h00);
        rd(8'h9B, 8'h20);
        rd(8'h55, 8'h00);
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h7F);
        wr(8'h98, 8'hFF);
        rd(8'h98, 8'h0F);
        d = $random(seed);
        wr(8'h99, d);
        rd(8'h99, d);
        wr(8'h98, 8'h00);
        wr(8'h99, 8'h00);
        $display("registers done");
        for (int c = 0; c < 8; c++) begin
            nb = c == 7 ? 9 : (c > 3 ? 8 : 5 + c);
            {d, n9} = $random(seed);
            m = 8'hFF >> (8 - nb);
            peerBits = nb;
            wr(8'h20, {5'h0, c[1:0], 1'b0});
            wr(8'h9A, {5'h01, c[2], 1'b0, n9});
            txQ.push_back(nb == 9 ? {n9, d} : {1'b0, d & m});
            wr(8'h0C, d);
            waitq;
        end
        wr(8'h20, 8'h06);
        peerBits = 4'h8;
        wr(8'h9A, 8'h08);
        d = $random(seed);
        txQ.push_back({1'b0, d});
        wr(8'h0C, d);
        wr(8'h9A, 8'h60);
        check(serialOutOe, 1'b1);
        waitq;
        check(serialOutOe, 1'b0);
        globalIrqEn = 1'b1;
        cyc(2);
        check(irqTxDone, 1'b1);
        check(irqTxEmpty, 1'b1);
        globalIrqEn = 1'b0;
        cyc(2);
        check(irqTxDone, 1'b0);
        check(irqTxEmpty, 1'b0);
        rd(8'h9B, 8'h60);
        txDoneIrqAck = 1'b1;
        cyc(1);
        txDoneIrqAck = 1'b0;
        rd(8'h9B, 8'h20);
        $display("transmit done");
        wr(8'h9A, 8'h90);
        wr(8'h20, 8'h26);
        globalIrqEn = 1'b1;
        {d, e} = $random(seed);
        peer.send({2'b11, ^d, d, 1'b0}, 11);
        peer.send({2'b11, ~^e, e, 1'b0}, 11);
        cyc(4);
        check(irqRxDone, 1'b1);
        globalIrqEn = 1'b0;
        cyc(2);
        check(irqRxDone, 1'b0);
        rd(8'h9B, 8'hA0);
        rd(8'h0C, d);
        rd(8'h9B, 8'hA4);
        rd(8'h0C, e);
        wr(8'h20, 8'h36);
        peer.send({2'b11, ~^d, d, 1'b0}, 11);
        cyc(4);
        rd(8'h9B, 8'hA0);
        rd(8'h0C, d);
        wr(8'h20, 8'h00);
        peer.send({6'h3F, e[4:0], 1'b0}, 7);
        cyc(4);
        rd(8'h0C, {3'b000, e[4:0]});
        wr(8'h9A, 8'h14);
        wr(8'h20, 8'h06);
        {d, n9} = $random(seed);
        peer.send({2'b11, n9, d, 1'b0}, 11);
        cyc(4);
        rd(8'h9A, {6'h05, n9, 1'b0});
        rd(8'h0C, d);
        wr(8'h9A, 8'h10);
        wr(8'h9B, 8'h01);
        peer.send({3'b111, 1'b0, d[6:0], 1'b0}, 10);
        cyc(4);
        rd(8'h9B, 8'h21);
        peer.send({3'b111, 1'b1, d[6:0], 1'b0}, 10);
        cyc(4);
        rd(8'h9B, 8'hA1);
        wr(8'h9A, 8'h00);
        rd(8'h9B, 8'h21);
        wr(8'h20, 8'h40);
        wr(8'h9A, 8'h10);
        cyc(2);
        check(syncClockOe, 1'b1);
        $display("receive done");
        closeOut;
    end
endmodule

bind usc_control usc_control_sva chk (.*);

`default_nettype wire
